//--- hdl/ext_bus_master.sv
// external bus master: write cycles, locked sequences and dynamic sizing
`timescale 1ns/1ps
module ext_bus_master #(
	parameter bit REDUCED = 1'b0
) (
	// clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  srst_i,
	// core request and answer
	input  wire logic                  req_valid_i,
	output logic                       req_ready_o,
	input  wire ext_bus_pkg::bus_req_t req_i,
	output logic                       done_o,
	output logic [31:0]                rdata_o,
	// bus pins
	output ext_bus_pkg::bus_pins_t     pins_o,
	input  wire logic [15:0]           data_i,
	output logic                       address_strobe_n_o,
	output logic                       data_strobe_n_o,
	input  wire logic                  size_ack_wide_n_i,
	input  wire logic                  size_ack_narrow_n_i,
	output logic                       indivisible_cycle_n_o,
	// arbitration
	input  wire logic                  bus_request_in_n_i,
	output logic                       bus_grant_out_n_o
);
	// ------------------------------------------------------------
	// acknowledge and bus request synchronisation
	// ------------------------------------------------------------
	logic [1:0] ack_sync;

	ack_sync #(.WIDTH(2)) u_ack_sync (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.async_i   ({size_ack_wide_n_i, size_ack_narrow_n_i}),
		.sync_o    (ack_sync)
	);

	logic bus_req_sync;
	logic br_meta_reg;
	logic br_sync_reg;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			br_meta_reg <= 1'b1;
			br_sync_reg <= 1'b1;
		end else begin
			br_meta_reg <= bus_request_in_n_i;
			br_sync_reg <= br_meta_reg;
		end
	end
	assign bus_req_sync = ~br_sync_reg;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ext_bus_pkg::bus_state_t state_reg, state_next;
	logic [23:0] addr_reg,    addr_next;
	logic [2:0]  fcode_reg,   fcode_next;
	logic        rdwr_reg,    rdwr_next;
	logic [1:0]  size_reg,    size_next;
	logic [31:0] opnd_reg,    opnd_next;
	logic [31:0] rdata_reg,   rdata_next;
	logic [15:0] dout_reg,    dout_next;
	logic        doe_reg,     doe_next;
	logic        as_reg,      as_next;
	logic        ds_reg,      ds_next;
	logic        lock_reg,    lock_next;
	logic        last_reg,    last_next;
	logic        done_reg,    done_next;
	logic        grant_reg,   grant_next;
	logic        acked_reg,   acked_next;
	logic [1:0]  port_reg,    port_next;

	logic        port8;
	logic [1:0]  moved;
	logic [1:0]  ack_eff;

	// reserved pattern behaves as a sixteen-bit port
	always_comb begin
		ack_eff = ack_sync;
		if (ack_sync == ext_bus_pkg::ACK_RSVD) begin
			ack_eff = ext_bus_pkg::ACK_PORT16;
		end
	end

	assign port8 = (port_reg == ext_bus_pkg::ACK_PORT8);

	// bytes moved this cycle: one on 8-bit port, odd address or single-byte size, else two
	always_comb begin
		if (port8 || addr_reg[0] || size_reg == ext_bus_pkg::SIZE_ONE) begin
			moved = 2'h1;
		end else begin
			moved = 2'h2;
		end
	end

	// write lane steering from the most significant byte left
	function automatic logic [15:0] lanes(input logic [31:0] op,
		input logic [1:0] sz, input logic odd);
		logic [7:0] b0;
		logic [7:0] b1;
		b0 = op[31:24];
		b1 = op[23:16];
		if (sz == ext_bus_pkg::SIZE_ONE || odd) begin
			lanes = {b0, b0};
		end else begin
			lanes = {b0, b1};
		end
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		addr_next  = addr_reg;
		fcode_next = fcode_reg;
		rdwr_next  = rdwr_reg;
		size_next  = size_reg;
		opnd_next  = opnd_reg;
		rdata_next = rdata_reg;
		dout_next  = dout_reg;
		doe_next   = doe_reg;
		as_next    = as_reg;
		ds_next    = ds_reg;
		lock_next  = lock_reg;
		last_next  = last_reg;
		done_next  = 1'b0;
		grant_next = grant_reg;
		acked_next = acked_reg;
		port_next  = port_reg;

		// grant only when idle and not locked
		grant_next = bus_req_sync && state_reg == ext_bus_pkg::ST_IDLE
			&& !lock_reg;

		unique case (state_reg)
		ext_bus_pkg::ST_IDLE: begin
			if (req_valid_i && !grant_reg) begin
				state_next = ext_bus_pkg::ST_S0;
				addr_next  = req_i.addr;
				if (!(lock_reg && req_i.write)) begin
					fcode_next = req_i.fcode;
				end
				if (REDUCED) begin
					addr_next[23:20] = {4{req_i.addr[19]}};
					fcode_next[2]    = 1'b1;
				end
				rdwr_next  = ~req_i.write;
				size_next  = req_i.size;
				opnd_next  = req_i.wdata;
				lock_next  = req_i.locked;
				last_next  = req_i.last;
				if (!REDUCED && req_i.size != ext_bus_pkg::SIZE_ONE) begin
					addr_next[0] = 1'b0;
				end
			end
		end
		ext_bus_pkg::ST_S0: begin
			as_next    = 1'b1;
			acked_next = 1'b0;
			state_next = ext_bus_pkg::ST_S1;
			if (!rdwr_reg) begin
				dout_next = lanes(opnd_reg, size_reg, addr_reg[0]);
				doe_next  = 1'b1;
			end else begin
				ds_next = 1'b1;
			end
		end
		ext_bus_pkg::ST_S1: begin
			state_next = ext_bus_pkg::ST_S2;
		end
		ext_bus_pkg::ST_S2: begin
			if (ack_eff != ext_bus_pkg::ACK_WAIT) begin
				acked_next = 1'b1;
				port_next  = ack_eff;
			end
			if (!rdwr_reg) begin
				ds_next = 1'b1;
			end
			state_next = ext_bus_pkg::ST_S3;
		end
		ext_bus_pkg::ST_S3: begin
			if (acked_reg) begin
				state_next = ext_bus_pkg::ST_S4;
			end else if (ack_eff != ext_bus_pkg::ACK_WAIT) begin
				acked_next = 1'b1;
				port_next  = ack_eff;
			end
			// otherwise stay: wait state
		end
		ext_bus_pkg::ST_S4: begin
			// no control change here
			if (rdwr_reg) begin
				if (port8 || size_reg == ext_bus_pkg::SIZE_ONE
					|| addr_reg[0]) begin
					rdata_next = {rdata_reg[23:0],
						(!port8 && addr_reg[0]) ?
						data_i[7:0] : data_i[15:8]};
				end else begin
					rdata_next = {rdata_reg[15:0], data_i};
				end
			end
			state_next = ext_bus_pkg::ST_S5;
		end
		ext_bus_pkg::ST_S5: begin
			as_next    = 1'b0;
			ds_next    = 1'b0;
			state_next = ext_bus_pkg::ST_GAP;
			if (size_reg == moved) begin
				done_next = 1'b1;
			end
		end
		ext_bus_pkg::ST_GAP: begin
			doe_next = 1'b0;
			// pins advance only after the strobes are seen negated
			if (!done_reg) begin
				size_next  = size_reg - moved;
				addr_next  = addr_reg + {22'h0, moved};
				opnd_next  = (moved == 2'h1) ?
					{opnd_reg[23:0], 8'h00} : {opnd_reg[15:0], 16'h0000};
				state_next = ext_bus_pkg::ST_S0;
			end else begin
				state_next = ext_bus_pkg::ST_IDLE;
				if (lock_reg && (last_reg || !rdwr_reg && last_reg)) begin
					lock_next = 1'b0;
				end
				if (!lock_reg || last_reg) begin
					lock_next = 1'b0;
				end
				// address, direction, code held until the next request; only the code carries into a locked write
			end
		end
		default: state_next = ext_bus_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_reg <= ext_bus_pkg::ST_IDLE;
			addr_reg  <= '0;
			fcode_reg <= '0;
			rdwr_reg  <= 1'b1;
			size_reg  <= ext_bus_pkg::SIZE_ONE;
			opnd_reg  <= ext_bus_pkg::DATA_RESET;
			rdata_reg <= ext_bus_pkg::DATA_RESET;
			dout_reg  <= '0;
			doe_reg   <= 1'b0;
			as_reg    <= 1'b0;
			ds_reg    <= 1'b0;
			lock_reg  <= 1'b0;
			last_reg  <= 1'b0;
			done_reg  <= 1'b0;
			grant_reg <= 1'b0;
			acked_reg <= 1'b0;
			port_reg  <= ext_bus_pkg::ACK_PORT16;
		end else begin
			state_reg <= state_next;
			addr_reg  <= addr_next;
			fcode_reg <= fcode_next;
			rdwr_reg  <= rdwr_next;
			size_reg  <= size_next;
			opnd_reg  <= opnd_next;
			rdata_reg <= rdata_next;
			dout_reg  <= dout_next;
			doe_reg   <= doe_next;
			as_reg    <= as_next;
			ds_reg    <= ds_next;
			lock_reg  <= lock_next;
			last_reg  <= last_next;
			done_reg  <= done_next;
			grant_reg <= grant_next;
			acked_reg <= acked_next;
			port_reg  <= port_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign req_ready_o           = (state_reg == ext_bus_pkg::ST_IDLE)
		&& !grant_reg;
	assign done_o                = done_reg;
	assign rdata_o               = rdata_reg;
	assign address_strobe_n_o    = ~as_reg;
	assign data_strobe_n_o       = ~ds_reg;
	assign indivisible_cycle_n_o = ~lock_reg;
	assign bus_grant_out_n_o     = ~grant_reg;
	assign pins_o.addr           = addr_reg;
	assign pins_o.fcode          = fcode_reg;
	assign pins_o.rd_wr_n        = rdwr_reg;
	assign pins_o.size           = size_reg;
	assign pins_o.data           = dout_reg;
	assign pins_o.data_oe        = doe_reg;
endmodule // ext_bus_master

//--- pkg/ext_bus_pkg.sv
// constants, states and carrier types of the external bus master
package ext_bus_pkg;

	// transfer size encodings (bytes still to move)
	localparam logic [1:0] SIZE_FOUR  = 2'h0;
	localparam logic [1:0] SIZE_ONE   = 2'h1;
	localparam logic [1:0] SIZE_TWO   = 2'h2;
	localparam logic [1:0] SIZE_THREE = 2'h3;

	// size acknowledge patterns {wide, narrow}, active low
	localparam logic [1:0] ACK_WAIT   = 2'h3;
	localparam logic [1:0] ACK_PORT8  = 2'h2;
	localparam logic [1:0] ACK_PORT16 = 2'h1;
	localparam logic [1:0] ACK_RSVD   = 2'h0;

	// bus states: one-hot, each lasts one clock except ST_IDLE and a waiting ST_S3
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_S0    = 8'h02,
		ST_S1    = 8'h04,
		ST_S2    = 8'h08,
		ST_S3    = 8'h10,
		ST_S4    = 8'h20,
		ST_S5    = 8'h40,
		ST_GAP   = 8'h80
	} bus_state_t;

	// request from the core
	typedef struct packed {
		logic        write;
		logic        locked;
		logic        last;
		logic [1:0]  size;
		logic [23:0] addr;
		logic [2:0]  fcode;
		logic [31:0] wdata;
	} bus_req_t;

	// outputs that face the bus pins
	typedef struct packed {
		logic [23:0] addr;
		logic [2:0]  fcode;
		logic        rd_wr_n;
		logic [1:0]  size;
		logic [15:0] data;
		logic        data_oe;
	} bus_pins_t;

	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

endpackage

//--- hdl/ack_sync.sv
// two-flop synchroniser for the size acknowledge pins
`timescale 1ns/1ps
module ack_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             srst_i,
	// asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// negated acknowledges reset high
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule // ack_sync

//--- testbench/ext_bus_assertions.sv
// pin checker for the external bus master
`timescale 1ns/1ps
module ext_bus_checker (
	// --------
	// watched
	// --------
	input wire logic                   ref_clk_i,
	input wire logic                   srst_i,
	input wire ext_bus_pkg::bus_pins_t pins_o,
	input wire logic                   address_strobe_n_o,
	input wire logic                   data_strobe_n_o,
	input wire logic                   size_ack_wide_n_i,
	input wire logic                   size_ack_narrow_n_i,
	input wire logic                   indivisible_cycle_n_o,
	input wire logic                   bus_grant_out_n_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	logic ack_n;
	assign ack_n = size_ack_wide_n_i & size_ack_narrow_n_i;

	chk_ds_in_as: assert property (
		$fell(data_strobe_n_o) |-> !address_strobe_n_o)
		else $error("data strobe outside address strobe");
	chk_strobe_end: assert property (
		$rose(address_strobe_n_o) |-> data_strobe_n_o)
		else $error("strobes did not negate together");
	chk_hold_end: assert property (
		$rose(address_strobe_n_o) |-> $stable({pins_o.addr,
		pins_o.size, pins_o.fcode, pins_o.rd_wr_n}))
		else $error("cycle pins moved at strobe end");
	chk_pins_fixed: assert property (
		!address_strobe_n_o && !$past(address_strobe_n_o)
		|-> $stable({pins_o.addr, pins_o.size, pins_o.rd_wr_n}))
		else $error("cycle pins moved under address strobe");
	chk_wr_data: assert property (
		!data_strobe_n_o && !pins_o.rd_wr_n |-> pins_o.data_oe)
		else $error("write strobe without data driven");
	chk_lock_grant: assert property (
		!indivisible_cycle_n_o |-> bus_grant_out_n_o)
		else $error("grant during locked sequence");
	chk_wait_state: assert property (
		(!address_strobe_n_o && ack_n) [*3] |=> !address_strobe_n_o)
		else $error("cycle ended without acknowledge");
	chk_ack_end: assert property (
		!address_strobe_n_o && !ack_n |-> ##[1:12] address_strobe_n_o)
		else $error("cycle did not end after acknowledge");
endmodule // ext_bus_checker

bind ext_bus_master ext_bus_checker i_ext_bus_checker (
	.ref_clk_i(ref_clk_i),
	.srst_i(srst_i),
	.pins_o(pins_o),
	.address_strobe_n_o(address_strobe_n_o),
	.data_strobe_n_o(data_strobe_n_o),
	.size_ack_wide_n_i(size_ack_wide_n_i),
	.size_ack_narrow_n_i(size_ack_narrow_n_i),
	.indivisible_cycle_n_o(indivisible_cycle_n_o),
	.bus_grant_out_n_o(bus_grant_out_n_o)
);

//--- testbench/bus_responder.sv
// responder model: byte memory behind an 8 or 16-bit port
`timescale 1ns/1ps
module bus_responder (
	input  wire logic                   ref_clk_i,
	input  wire ext_bus_pkg::bus_pins_t pins_i,
	input  wire logic                   as_n_i,
	input  wire logic                   ds_n_i,
	input  wire logic [1:0]             mode_i,
	input  wire logic [3:0]             wait_i,
	output logic [15:0]                 data_o,
	output logic [1:0]                  ack_n_o
);
	logic [7:0]  mem [0:15];
	logic [3:0]  cnt;
	logic [3:0]  a;
	logic        wide;
	logic [15:0] rd;
	assign a = pins_i.addr[3:0];
	assign wide = mode_i != ext_bus_pkg::ACK_PORT8;
	assign rd = wide ? {mem[{a[3:1], 1'b0}], mem[{a[3:1], 1'b1}]}
		: {mem[a], ~mem[a]};
	// released bus shows the inverse so a stale value never passes
	assign data_o = as_n_i ? ~rd : rd;
	initial begin
		cnt = 4'h0;
		ack_n_o = 2'h3;
		for (int i = 0; i < 16; i++) mem[i] = 8'h00;
	end
	always @(posedge ref_clk_i) begin
		if (as_n_i) begin
			cnt <= 4'h0;
			ack_n_o <= 2'h3;
		end else if (cnt < wait_i) begin
			cnt <= cnt + 4'h1;
		end else begin
			ack_n_o <= mode_i;
		end
		if (!ds_n_i && !pins_i.rd_wr_n && !as_n_i) begin
			if (wide && a[0])
				mem[a] <= pins_i.data[7:0];
			else if (wide && pins_i.size != ext_bus_pkg::SIZE_ONE)
				{mem[a], mem[a | 4'h1]} <= pins_i.data;
			else
				mem[a] <= pins_i.data[15:8];
		end
	end
endmodule // bus_responder

//--- testbench/testbench.sv
// self-checking bench for the external bus master
`timescale 1ns/1ps
module testbench;
	logic                   ref_clk_i = 1'b0;
	logic                   srst_i = 1'b1;
	logic                   vld = 1'b0;
	logic                   brq_n = 1'b1;
	logic [1:0]             mode = ext_bus_pkg::ACK_PORT16;
	logic [3:0]             wt = 4'h0;
	ext_bus_pkg::bus_req_t  req = '0;
	ext_bus_pkg::bus_pins_t pins;
	logic                   rdy, done, as_n, ds_n, rmc_n, gnt_n;
	logic [31:0]            rdat;
	logic [15:0]            din;
	logic [1:0]             ack_n;
	logic [1:0]             szq [$];
	logic [23:0]            adq [$];
	logic [15:0]            lnq [$];
	int                     err_count = 0;
	int                     compares = 0;
	always #10 ref_clk_i = ~ref_clk_i;
	always @(negedge as_n) begin
		szq.push_back(pins.size);
		adq.push_back(pins.addr);
	end
	always @(negedge ds_n) if (!pins.rd_wr_n) lnq.push_back(pins.data);

	ext_bus_master i_ext_bus_master (.ref_clk_i(ref_clk_i),
		.srst_i(srst_i), .req_valid_i(vld), .req_ready_o(rdy),
		.req_i(req), .done_o(done), .rdata_o(rdat), .pins_o(pins),
		.data_i(din), .address_strobe_n_o(as_n),
		.data_strobe_n_o(ds_n), .size_ack_wide_n_i(ack_n[1]),
		.size_ack_narrow_n_i(ack_n[0]), .indivisible_cycle_n_o(rmc_n),
		.bus_request_in_n_i(brq_n), .bus_grant_out_n_o(gnt_n));
	bus_responder i_bus_responder (.ref_clk_i(ref_clk_i), .pins_i(pins),
		.as_n_i(as_n), .ds_n_i(ds_n), .mode_i(mode), .wait_i(wt),
		.data_o(din), .ack_n_o(ack_n));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic w, lk, ls, input logic [1:0] sz,
		input logic [23:0] ad, input logic [31:0] wd);
		int n;
		szq.delete();
		adq.delete();
		lnq.delete();
		@(negedge ref_clk_i);
		req = '{w, lk, ls, sz, ad, 3'h5, wd};
		vld = 1'b1;
		for (n = 0; n < 50 && rdy !== 1'b1; n++) @(negedge ref_clk_i);
		@(negedge ref_clk_i);
		vld = 1'b0;
		for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge ref_clk_i);
	endtask
	// sizes and addresses of each bus cycle, earlier cycles in higher bits
	task automatic seq(input logic [7:0] ex, input int k,
		input logic [23:0] a0, input int st);
		logic [7:0] g;
		g = 8'h00;
		check(32'(szq.size()), 32'(k));
		for (int i = 0; i < k; i++) begin
			g = {g[5:0], szq[i]};
			check({8'h00, adq[i]}, {8'h00, a0} + 32'(st * i));
		end
		check({24'h0, g}, {24'h0, ex});
	endtask

	task automatic t_long16;
		mode = ext_bus_pkg::ACK_PORT16;
		op(1, 0, 0, 2'h0, 24'h4, 32'h1122_3344);
		seq(8'h02, 2, 24'h4, 2);
		check({16'h0, lnq[0]}, 32'h1122);
		op(0, 0, 0, 2'h0, 24'h4, 32'h0);
		check(rdat, 32'h1122_3344);
		$display("long word to 16-bit port done");
	endtask
	task automatic t_long8;
		mode = ext_bus_pkg::ACK_PORT8;
		wt = 4'h4;
		op(1, 0, 0, 2'h0, 24'h8, 32'ha1b2_c3d4);
		seq(8'h39, 4, 24'h8, 1);
		check({16'h0, lnq[3]}, 32'hd4d4);
		op(0, 0, 0, 2'h0, 24'h8, 32'h0);
		check(rdat, 32'ha1b2_c3d4);
		wt = 4'h0;
		$display("long word to 8-bit port done");
	endtask
	task automatic t_byte_odd;
		mode = ext_bus_pkg::ACK_PORT16;
		op(1, 0, 0, 2'h1, 24'h1, 32'h5a00_0000);
		check({16'h0, lnq[0]}, 32'h5a5a);
		op(0, 0, 0, 2'h1, 24'h1, 32'h0);
		check({24'h0, rdat[7:0]}, 32'h5a);
		$display("odd byte done");
	endtask
	task automatic t_rsvd;
		mode = ext_bus_pkg::ACK_RSVD;
		op(1, 0, 0, 2'h2, 24'h2, 32'h7788_0000);
		seq(8'h02, 1, 24'h2, 2);
		op(0, 0, 0, 2'h2, 24'h2, 32'h0);
		check({16'h0, rdat[15:0]}, 32'h7788);
		$display("reserved acknowledge done");
	endtask
	task automatic t_locked;
		mode = ext_bus_pkg::ACK_PORT16;
		op(0, 1, 0, 2'h0, 24'h4, 32'h0);
		brq_n = 1'b0;
		check({31'h0, rmc_n}, 32'h0);
		check({31'h0, pins.rd_wr_n}, 32'h1);
		check({8'h0, pins.addr}, 32'h6);
		op(1, 1, 1, 2'h2, 24'h4, 32'h99aa_0000);
		@(negedge ref_clk_i);
		check({31'h0, rmc_n}, 32'h1);
		repeat (2) @(negedge ref_clk_i);
		check({31'h0, gnt_n}, 32'h0);
		brq_n = 1'b1;
		op(0, 0, 0, 2'h0, 24'h4, 32'h0);
		check(rdat, 32'h99aa_3344);
		$display("locked sequence done");
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#(20 * 8000);
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (5) @(negedge ref_clk_i);
		srst_i = 1'b0;
		t_long16();
		t_long8();
		t_byte_odd();
		t_rsvd();
		t_locked();
		give_verdict();
	end
endmodule // testbench
